// ---- src/fhl_pkg.sv ----
// constants, offsets and reset values for the data-link code and packet fifo registers
package fhl_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_CODE     = 8'h04;
  localparam logic [7:0] ADDR_RX_FIFO     = 8'h05;
  localparam logic [7:0] ADDR_TX_STATUS   = 8'h06;
  localparam logic [7:0] ADDR_TX_CODE     = 8'h07;
  localparam logic [7:0] ADDR_TX_FIFO     = 8'h08;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_DETECT_LATCHED = 7;
  localparam int BIT_DETECT_LIVE    = 6;
  localparam int BIT_SEND_TRIGGER   = 7;
  localparam int BIT_SOURCE_SEL     = 6;
  localparam int BIT_TX_EMPTY       = 2;
  localparam int BIT_TX_FULL        = 1;
  localparam int BIT_TX_UNDERRUN    = 0;
  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [5:0] RST_RX_CODE    = 6'h3f;
  localparam logic [7:0] RST_TX_CONTROL = 8'h00;
  localparam int         FIFO_BYTES     = 64;
  localparam int         CODE_FRAME     = 16;
  localparam logic [4:0] FRAME_LAST     = 5'h0f;
  localparam logic [4:0] FRAME_LOST     = 5'h10;
  localparam int         VALID_REPEATS  = 2;
endpackage

// ---- src/fhl_link_regs.sv ----
// packet fifo and the register block with code detector and code sender
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// byte fifo with valid and ready on both sides
// ----------------------------------------------------------------
module fhl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] in_data_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  output logic [W-1:0]      out_data_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    rdy;
    logic                    vld;
    logic [W-1:0]            head;
  } fhl_fifo_t;

  fhl_fifo_t st;
  fhl_fifo_t next_st;
  logic      push;
  logic      pop;

  assign in_ready_out  = st.rdy;
  assign out_valid_out = st.vld;
  assign out_data_out  = st.head;
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_ready_in && out_valid_out;

  // pointers wrap at depth so any depth works, not only powers of two
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data_in;
      next_st.wp = (st.wp == LAST_IDX) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == LAST_IDX) ? '0 : st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    next_st.rdy  = (next_st.cnt != FULL_CNT);  // flags and head kept in flops for clean ports
    next_st.vld  = (next_st.cnt != '0);
    next_st.head = next_st.mem[next_st.rp];
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ----------------------------------------------------------------
// register block
// ----------------------------------------------------------------
module fhl_link_regs #(
  parameter int FIFO_DEPTH = fhl_pkg::FIFO_BYTES,
  parameter int REPEATS    = fhl_pkg::VALID_REPEATS
) (
  input  wire logic       REF_CLK_IN,
  input  wire logic       RESET_N_IN,
  input  wire logic       CS_N_IN,
  input  wire logic       RD_N_IN,
  input  wire logic       WR_N_IN,
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] DATA_IN,
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE_OUT,
  input  wire logic       RX_BIT_EN_IN,
  input  wire logic       RX_LINK_BIT_IN,
  input  wire logic [7:0] RX_BYTE_IN,
  input  wire logic       RX_BYTE_VALID_IN,
  output logic            RX_BYTE_READY_OUT,
  output logic      [7:0] TX_BYTE_OUT,
  output logic            TX_BYTE_VALID_OUT,
  input  wire logic       TX_BYTE_READY_IN,
  input  wire logic       TX_MSG_ACTIVE_IN,
  output logic            TX_ABORT_OUT,
  input  wire logic       TX_BIT_EN_IN,
  input  wire logic       TX_HDLC_BIT_IN,
  input  wire logic       EXT_LINK_DATA_IN,
  output logic            TX_LINK_DATA_OUT,
  input  wire logic [7:0] LINK_IRQ_MASK_IN,
  output logic            CODE_CHANGE_IRQ_OUT
);
  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] rd_sync;
    logic [2:0] wr_sync;
    logic [2:0] ext_sync;
    logic       cs_act;
    logic       rd_act;
    logic       wr_act;
    logic       ext_bit;
    logic [7:0] rd_data;
    logic       oe;
    logic [15:0] rx_shift;
    logic [4:0] rx_since;
    logic [5:0] rx_prev;
    logic [3:0] rx_rep;
    logic       live;
    logic       detect_latched;
    logic [5:0] rx_code;
    logic       irq;
    logic       underrun;
    logic       abort_sent;
    logic       abort;
    logic [7:0] tx_control;
    logic       send_pending;
    logic       sending;
    logic [15:0] tx_shift;
    logic [4:0] tx_bits;
    logic       link_out;
  } fhl_regs_t;

  fhl_regs_t st;
  fhl_regs_t next_st;

  logic       rx_fifo_pop;
  logic [7:0] rx_fifo_data;
  logic       rx_fifo_valid;
  logic       tx_fifo_push;
  logic       tx_fifo_ready;
  logic       tx_fifo_valid;
  logic       rd_start;
  logic       wr_start;
  logic       rx_match;
  logic [5:0] rx_word;

  // a code frame, oldest bit first: eight ones, zero, six code bits, zero
  function automatic logic code_frame_ok(input logic [15:0] w);
    code_frame_ok = (w[7:0] == 8'hff) && !w[8] && !w[15];
  endfunction

  function automatic logic [15:0] code_frame(input logic [5:0] c);
    code_frame = {1'b0, c, 1'b0, 8'hff};
  endfunction

  // ----------------------------------------------------------------
  // packet fifos
  // ----------------------------------------------------------------
  fhl_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_in        (REF_CLK_IN),
    .rst_n_in      (RESET_N_IN),
    .in_data_in    (RX_BYTE_IN),
    .in_valid_in   (RX_BYTE_VALID_IN),
    .in_ready_out  (RX_BYTE_READY_OUT),
    .out_data_out  (rx_fifo_data),
    .out_valid_out (rx_fifo_valid),
    .out_ready_in  (rx_fifo_pop)
  );

  fhl_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_in        (REF_CLK_IN),
    .rst_n_in      (RESET_N_IN),
    .in_data_in    (DATA_IN),
    .in_valid_in   (tx_fifo_push),
    .in_ready_out  (tx_fifo_ready),
    .out_data_out  (TX_BYTE_OUT),
    .out_valid_out (tx_fifo_valid),
    .out_ready_in  (TX_BYTE_READY_IN)
  );

  // host strobes act once their synchronised level is stable
  assign rd_start = (st.rd_sync[1] == st.rd_sync[2]) && !st.rd_sync[2] && !st.rd_act &&
                    (st.cs_sync[1] == st.cs_sync[2]) && !st.cs_sync[2];
  assign wr_start = (st.wr_sync[1] == st.wr_sync[2]) && !st.wr_sync[2] && !st.wr_act &&
                    (st.cs_sync[1] == st.cs_sync[2]) && !st.cs_sync[2];
  assign rx_fifo_pop  = rd_start && (ADDR_IN == fhl_pkg::ADDR_RX_FIFO);
  assign tx_fifo_push = wr_start && (ADDR_IN == fhl_pkg::ADDR_TX_FIFO);
  assign rx_match = code_frame_ok({RX_LINK_BIT_IN, st.rx_shift[15:1]});  // frame this bit ends
  assign rx_word  = st.rx_shift[15:10];

  assign DATA_OUT            = st.rd_data;
  assign DATA_OE_OUT         = st.oe;
  assign TX_BYTE_VALID_OUT   = tx_fifo_valid;
  assign TX_ABORT_OUT        = st.abort;
  assign TX_LINK_DATA_OUT    = st.link_out;
  assign CODE_CHANGE_IRQ_OUT = st.irq;

  always_comb begin
    next_st = st;
    // ----------------------------------------------------------------
    // input synchronisers, stage 0 is read only by stage 1
    // ----------------------------------------------------------------
    next_st.cs_sync  = {st.cs_sync[1:0], CS_N_IN};
    next_st.rd_sync  = {st.rd_sync[1:0], RD_N_IN};
    next_st.wr_sync  = {st.wr_sync[1:0], WR_N_IN};
    next_st.ext_sync = {st.ext_sync[1:0], EXT_LINK_DATA_IN};
    next_st.ext_bit = (st.ext_sync[1] == st.ext_sync[2]) ? st.ext_sync[2] : st.ext_bit;
    next_st.rd_act  = (st.rd_sync[1] == st.rd_sync[2]) ? !st.rd_sync[2] : st.rd_act;
    next_st.wr_act  = (st.wr_sync[1] == st.wr_sync[2]) ? !st.wr_sync[2] : st.wr_act;
    next_st.cs_act  = (st.cs_sync[1] == st.cs_sync[2]) ? !st.cs_sync[2] : st.cs_act;
    next_st.oe = next_st.cs_act && next_st.rd_act;
    // ----------------------------------------------------------------
    // host read: capture data, apply read-clear side effects
    // ----------------------------------------------------------------
    if (rd_start) begin
      if (ADDR_IN == fhl_pkg::ADDR_RX_CODE) begin
        next_st.rd_data = {st.detect_latched, st.live, st.rx_code};
        next_st.detect_latched = 1'b0;
      end else if (ADDR_IN == fhl_pkg::ADDR_RX_FIFO) begin
        next_st.rd_data = rx_fifo_data;
      end else if (ADDR_IN == fhl_pkg::ADDR_TX_STATUS) begin
        next_st.rd_data = 8'h00;
        next_st.rd_data[fhl_pkg::BIT_TX_EMPTY] = !tx_fifo_valid;
        next_st.rd_data[fhl_pkg::BIT_TX_FULL] = !tx_fifo_ready;
        next_st.rd_data[fhl_pkg::BIT_TX_UNDERRUN] = st.underrun;
        next_st.underrun = 1'b0;
      end else if (ADDR_IN == fhl_pkg::ADDR_TX_CODE) begin
        next_st.rd_data = st.tx_control;
      end else begin
        next_st.rd_data = 8'h00;
      end
    end
    // ----------------------------------------------------------------
    // host write to the transmit code control register
    // ----------------------------------------------------------------
    if (wr_start && (ADDR_IN == fhl_pkg::ADDR_TX_CODE)) begin
      next_st.tx_control = DATA_IN;
      if (DATA_IN[fhl_pkg::BIT_SEND_TRIGGER] && !st.tx_control[fhl_pkg::BIT_SEND_TRIGGER]) begin
        next_st.send_pending = 1'b1;
      end
    end
    // ----------------------------------------------------------------
    // receive code detector, one step per line bit
    // ----------------------------------------------------------------
    if (RX_BIT_EN_IN) begin
      next_st.rx_shift = {RX_LINK_BIT_IN, st.rx_shift[15:1]};
      next_st.rx_since = (st.rx_since == fhl_pkg::FRAME_LOST) ? st.rx_since : st.rx_since + 1'b1;
      if (rx_match) begin
        next_st.rx_since = 5'h00;
        next_st.rx_prev = rx_word;
        // a code counts only when repeated back to back on frame spacing
        if ((rx_word == st.rx_prev) && (st.rx_since == fhl_pkg::FRAME_LAST)) begin
          next_st.rx_rep = (st.rx_rep == 4'hf) ? st.rx_rep : st.rx_rep + 1'b1;
        end else begin
          next_st.rx_rep = 4'h1;
          next_st.live = 1'b0;
        end
        if (next_st.rx_rep >= 4'(REPEATS)) begin
          next_st.live = 1'b1;
          next_st.rx_code = rx_word;
        end
      end else if (st.rx_since == fhl_pkg::FRAME_LAST) begin
        // a frame slot passed without a code frame
        next_st.rx_rep = 4'h0;
        next_st.live = 1'b0;
      end
    end
    // change of state sets the latch after any read clear, so the set wins
    if (next_st.live != st.live) begin
      next_st.detect_latched = 1'b1;
    end
    next_st.irq = next_st.detect_latched && LINK_IRQ_MASK_IN[7];
    // ----------------------------------------------------------------
    // transmit underrun: fifo dry while a message is open
    // ----------------------------------------------------------------
    next_st.abort = 1'b0;
    if (!TX_MSG_ACTIVE_IN) begin
      next_st.abort_sent = 1'b0;
    end else if (TX_BYTE_READY_IN && !tx_fifo_valid && !st.abort_sent) begin
      next_st.abort = 1'b1;
      next_st.abort_sent = 1'b1;
      next_st.underrun = 1'b1;
    end
    // ----------------------------------------------------------------
    // code sender and link source select, one step per line bit
    // ----------------------------------------------------------------
    if (TX_BIT_EN_IN) begin
      if (st.sending) begin
        next_st.tx_shift = {1'b0, st.tx_shift[15:1]};
        next_st.tx_bits = st.tx_bits + 1'b1;
        if (st.tx_bits == fhl_pkg::FRAME_LAST) begin
          // keep repeating whole frames while the trigger stays set
          next_st.tx_bits = 5'h00;
          if (next_st.tx_control[fhl_pkg::BIT_SEND_TRIGGER]) begin
            next_st.tx_shift = code_frame(next_st.tx_control[5:0]);
          end else begin
            next_st.sending = 1'b0;
          end
        end
      end else if (st.send_pending) begin
        next_st.send_pending = 1'b0;
        next_st.sending = 1'b1;
        next_st.tx_bits = 5'h00;
        next_st.tx_shift = code_frame(st.tx_control[5:0]);
      end
      if (!st.tx_control[fhl_pkg::BIT_SOURCE_SEL]) begin
        next_st.link_out = st.ext_bit;
      end else if (next_st.sending) begin
        next_st.link_out = next_st.tx_shift[0];
      end else begin
        next_st.link_out = TX_HDLC_BIT_IN;
      end
    end
  end

  // all control state resets to constants only
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st            <= '0;
      st.cs_sync    <= 3'h7;
      st.rd_sync    <= 3'h7;
      st.wr_sync    <= 3'h7;
      st.rx_code    <= fhl_pkg::RST_RX_CODE;
      st.rx_prev    <= fhl_pkg::RST_RX_CODE;
      st.tx_control <= fhl_pkg::RST_TX_CONTROL;
    end else begin
      st <= next_st;
    end
  end
endmodule

`default_nettype wire

// ---- src/fhl_unused_placeholder_none.sv ----
// intentionally empty: all logic lives in fhl_link_regs.sv

// ---- sim/fhl_link_regs_asserts.sv ----
// port-level checks for the link register block
`timescale 1ns/1ps
`default_nettype none
module fhl_link_regs_chk (
  input wire logic       REF_CLK_IN,
  input wire logic       RESET_N_IN,
  input wire logic       CS_N_IN,
  input wire logic       RD_N_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic       DATA_OE_OUT,
  input wire logic [7:0] TX_BYTE_OUT,
  input wire logic       TX_BYTE_VALID_OUT,
  input wire logic       TX_BYTE_READY_IN,
  input wire logic       TX_MSG_ACTIVE_IN,
  input wire logic       TX_ABORT_OUT,
  input wire logic       TX_BIT_EN_IN,
  input wire logic       TX_LINK_DATA_OUT,
  input wire logic [7:0] LINK_IRQ_MASK_IN,
  input wire logic       CODE_CHANGE_IRQ_OUT
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  // remembers an abort until its message closes
  logic abort_seen;
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      abort_seen <= 1'b0;
    end else if (!TX_MSG_ACTIVE_IN) begin
      abort_seen <= 1'b0;
    end else if (TX_ABORT_OUT) begin
      abort_seen <= 1'b1;
    end
  end
  sequence s_rd_req;
    !CS_N_IN && !RD_N_IN;
  endsequence
  sequence s_abort;
    TX_ABORT_OUT;
  endsequence
  property p_oe_cause;
    $rose(DATA_OE_OUT) |-> $past(!CS_N_IN && !RD_N_IN, 2);
  endproperty
  property p_oe_hold;
    s_rd_req and DATA_OE_OUT |=> DATA_OE_OUT;
  endproperty
  property p_data_on_read;
    $changed(DATA_OUT) |-> $rose(DATA_OE_OUT);
  endproperty
  property p_abort_cause;
    s_abort |-> $past(TX_MSG_ACTIVE_IN && TX_BYTE_READY_IN && !TX_BYTE_VALID_OUT);
  endproperty
  // the abort is re-armed only once the message ends
  property p_abort_once;
    s_abort |-> !abort_seen;
  endproperty
  property p_tx_hold;
    TX_BYTE_VALID_OUT && !TX_BYTE_READY_IN |=> TX_BYTE_VALID_OUT && $stable(TX_BYTE_OUT);
  endproperty
  property p_link_hold;
    !TX_BIT_EN_IN |=> $stable(TX_LINK_DATA_OUT);
  endproperty
  property p_irq_mask;
    !LINK_IRQ_MASK_IN[7] |=> !CODE_CHANGE_IRQ_OUT;
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("read output enable rose without a read strobe");
  a_oe_hold: assert property (p_oe_hold)
    else $error("read output enable dropped while strobe held");
  a_data_on_read: assert property (p_data_on_read)
    else $error("read data changed outside a read");
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort without an underrun");
  a_abort_once: assert property (p_abort_once)
    else $error("second abort in one message");
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx fifo head moved while stalled");
  a_link_hold: assert property (p_link_hold)
    else $error("link bit moved without a bit slot");
  a_irq_mask: assert property (p_irq_mask)
    else $error("code change interrupt while masked");
endmodule
bind fhl_link_regs fhl_link_regs_chk fhl_link_regs_chk_inst (
  .REF_CLK_IN, .RESET_N_IN, .CS_N_IN, .RD_N_IN, .DATA_OUT, .DATA_OE_OUT, .TX_BYTE_OUT,
  .TX_BYTE_VALID_OUT, .TX_BYTE_READY_IN, .TX_MSG_ACTIVE_IN, .TX_ABORT_OUT, .TX_BIT_EN_IN,
  .TX_LINK_DATA_OUT, .LINK_IRQ_MASK_IN, .CODE_CHANGE_IRQ_OUT
);
`default_nettype wire

// ---- sim/fhl_link_partner.sv ----
// far-end model: code frames and bytes in, bit slots and sinks for what goes out
`timescale 1ns/1ps
`default_nettype none
module fhl_link_partner (
  input  wire logic       clk_in,
  output logic            rx_en_out,
  output logic            rx_bit_out,
  output logic [7:0]      rx_byte_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output logic            tx_en_out,
  input  wire logic       tx_link_in,
  input  wire logic       abort_in
);
  logic [1:0] div = 2'h0;
  logic       en_q = 1'b0;
  logic       txq[$];
  logic [7:0] byteq[$];
  int         aborts = 0;
  // outputs idle at time zero; the sink starts stalled
  initial begin
    rx_en_out = 1'b0;
    rx_bit_out = 1'b0;
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
    tx_en_out = 1'b0;
  end
  // one link bit slot every fourth cycle, launched off the sampling edge
  always @(negedge clk_in) begin
    div <= div + 2'h1;
    tx_en_out <= (div == 2'h3);
  end
  // a bit launched at a slot edge is settled by the following edge
  always @(posedge clk_in) begin
    en_q <= tx_en_out;
    if (en_q) txq.push_back(tx_link_in);
    if (tx_valid_in && tx_ready_out) byteq.push_back(tx_byte_in);
    if (abort_in) aborts++;
  end
  // the line shows the inverse between bits so a stale level never matches
  task automatic send_bit(input logic b);
    @(negedge clk_in);
    rx_bit_out = b;
    rx_en_out = 1'b1;
    @(negedge clk_in);
    rx_en_out = 1'b0;
    rx_bit_out = ~b;
  endtask
  // frame oldest first: eight ones, zero, code bit 0 to bit 5, zero
  task automatic send_code(input logic [5:0] c, input int frames);
    logic [15:0] f;
    f = {8'hff, 1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0};
    repeat (frames) for (int i = 15; i >= 0; i--) send_bit(f[i]);
  endtask
  // wait for ready on settled edges, then let one rising edge take the byte
  task automatic push_byte(input logic [7:0] b);
    @(negedge clk_in);
    rx_byte_out = b;
    rx_valid_out = 1'b1;
    for (int n = 0; n < 20 && !rx_ready_in; n++) @(negedge clk_in);
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    rx_byte_out = ~b;
  endtask
endmodule
`default_nettype wire

// ---- sim/fhl_link_regs_tb.sv ----
// self-checking bench for the link register block
`timescale 1ns/1ps
`default_nettype none
module fhl_link_regs_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cs_n = 1'b1;
  logic       rd_n = 1'b1;
  logic       wr_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] mask = 8'h00;
  logic       ext = 1'b0;
  logic       msg = 1'b0;
  logic       hdlc = 1'b0;
  logic [7:0] dout, txb, rxb, q;
  logic       oe, rx_en, rx_bit, rxv, rxr, txv, txr, abort, tx_en, link, irq;
  wire  logic [7:0] bus = oe ? dout : wdat;
  int         err_total = 0;
  int         samples_checked = 0;
  // 40 MHz reference
  initial forever #12.5 clk = ~clk;
  fhl_link_regs #(.FIFO_DEPTH(4)) fhl_link_regs_inst (
    .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
    .WR_N_IN(wr_n), .ADDR_IN(addr), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE_OUT(oe),
    .RX_BIT_EN_IN(rx_en), .RX_LINK_BIT_IN(rx_bit), .RX_BYTE_IN(rxb),
    .RX_BYTE_VALID_IN(rxv), .RX_BYTE_READY_OUT(rxr), .TX_BYTE_OUT(txb),
    .TX_BYTE_VALID_OUT(txv), .TX_BYTE_READY_IN(txr), .TX_MSG_ACTIVE_IN(msg),
    .TX_ABORT_OUT(abort), .TX_BIT_EN_IN(tx_en), .TX_HDLC_BIT_IN(hdlc),
    .EXT_LINK_DATA_IN(ext), .TX_LINK_DATA_OUT(link), .LINK_IRQ_MASK_IN(mask),
    .CODE_CHANGE_IRQ_OUT(irq)
  );
  fhl_link_partner fhl_link_partner_inst (
    .clk_in(clk), .rx_en_out(rx_en), .rx_bit_out(rx_bit), .rx_byte_out(rxb),
    .rx_valid_out(rxv), .rx_ready_in(rxr), .tx_byte_in(txb), .tx_valid_in(txv),
    .tx_ready_out(txr), .tx_en_out(tx_en), .tx_link_in(link), .abort_in(abort)
  );
  // ----
  // tasks
  // ----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // a write has no answer, so the strobe is held past the sync depth
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    addr = a;
    wdat = d;
    cs_n = 1'b0;
    wr_n = !w;
    rd_n = w;
    if (w) repeat (6) @(negedge clk);
    else while (oe !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      err_total++;
      $display("ERROR %0t read never answered", $time);
      wrap_up();
    end
    q = dout;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    acc(1'b0, a, 8'h00);
    chk(q & m, exp, $sformatf("read %h", a));
  endtask
  task automatic frame_chk(input logic [5:0] c);
    int i;
    logic [15:0] got;
    i = 0;
    for (int n = 0; n < 400 && fhl_link_partner_inst.txq.size() < 60; n++) @(negedge clk);
    while (i < 40 && fhl_link_partner_inst.txq[i] !== 1'b1) i++;
    for (int k = 0; k < 16; k++) got[15-k] = fhl_link_partner_inst.txq[i+k];
    chk(got[15:8], 8'hff, "frame head");
    chk(got[7:0], {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0}, "frame code");
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    rd(8'h04, 8'h3f, 8'hff);
    rd(8'h06, 8'h04, 8'h07);
    rd(8'h07, 8'h00, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    acc(1'b1, 8'h04, 8'h00);
    rd(8'h04, 8'h3f, 8'hff);
    $display("%0t test reset done", $time);
    ext = 1'b1;
    repeat (20) @(negedge clk);
    chk(8'(link), 8'h01, "ext source");
    acc(1'b1, 8'h07, 8'h40);
    repeat (20) @(negedge clk);
    chk(8'(link), 8'h00, "onboard source");
    hdlc = 1'b1;
    repeat (20) @(negedge clk);
    chk(8'(link), 8'h01, "hdlc bit");
    ext = 1'b0;
    hdlc = 1'b0;
    repeat (20) @(negedge clk);
    fhl_link_partner_inst.txq.delete();
    acc(1'b1, 8'h07, 8'hcb);
    frame_chk(6'h0b);
    acc(1'b1, 8'h07, 8'h4b);
    rd(8'h07, 8'h4b, 8'hff);
    $display("%0t test code send done", $time);
    mask = 8'h80;
    fhl_link_partner_inst.send_code(6'h15, 2);
    repeat (4) @(negedge clk);
    chk(8'(irq), 8'h01, "irq set");
    rd(8'h04, 8'hd5, 8'hff);
    rd(8'h04, 8'h55, 8'hff);
    chk(8'(irq), 8'h00, "irq clear");
    mask = 8'h00;
    repeat (20) fhl_link_partner_inst.send_bit(1'b0);
    repeat (4) @(negedge clk);
    chk(8'(irq), 8'h00, "irq masked");
    mask = 8'h80;
    repeat (4) @(negedge clk);
    chk(8'(irq), 8'h01, "irq unmasked");
    rd(8'h04, 8'h95, 8'hff);
    $display("%0t test code detect done", $time);
    for (int k = 0; k < 4; k++) fhl_link_partner_inst.push_byte(8'h81 >> k);
    chk(8'(rxr), 8'h00, "rx fifo full");
    for (int k = 0; k < 4; k++) rd(8'h05, 8'h81 >> k, 8'hff);
    $display("%0t test rx fifo done", $time);
    for (int k = 0; k < 5; k++) acc(1'b1, 8'h08, 8'(8'h11 * (k + 1)));
    rd(8'h06, 8'h02, 8'h07);
    fhl_link_partner_inst.tx_ready_out = 1'b1;
    repeat (10) @(negedge clk);
    for (int k = 0; k < 4; k++) chk(fhl_link_partner_inst.byteq[k], 8'(8'h11 * (k + 1)), "tx byte");
    chk(8'(fhl_link_partner_inst.byteq.size()), 8'h04, "tx count");
    rd(8'h06, 8'h04, 8'h07);
    $display("%0t test tx fifo done", $time);
    msg = 1'b1;
    repeat (6) @(negedge clk);
    msg = 1'b0;
    chk(8'(fhl_link_partner_inst.aborts), 8'h01, "aborts");
    rd(8'h04, 8'h15, 8'hff);
    rd(8'h06, 8'h05, 8'h07);
    rd(8'h06, 8'h04, 8'h07);
    $display("%0t test underrun done", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
